// ==== pwm_cutoff_ctrl.sv ====
// What this block does
// - channel-1 pin A cutoff field, bits 7:6
// - channel-1 pin B cutoff field, bits 5:4
// - channel-1 pin C cutoff field, bits 3:2
// - channel-1 pin D cutoff field, bits 1:0
// - channel-0 pin C cutoff field, bits 3:2
// - channel-0 pin D cutoff field, bits 1:0
// - one disable bit per pin, eight bits
// - disable 0 timer drives, 1 port drives
//
// Added by the designer: the register offsets and the Wishbone interface to the registers.
`include "pwm_cutoff_map.svh"
`timescale 1ns/1ns
module pwm_cutoff_ctrl
#(
   parameter int ADDR_WIDTH = 8,
   parameter int PIN_COUNT  = 8
)
(
   // clock and reset
   input  wire logic                              sys_clk,
   input  wire logic                              sys_rst,
   // wishbone slave
   input  wire logic                              wb_cyc_i,
   input  wire logic                              wb_stb_i,
   input  wire logic                              wb_we_i,
   input  wire logic [ADDR_WIDTH-1:0]             wb_adr_i,
   input  wire logic [3:0]                        wb_sel_i,
   input  wire logic [31:0]                       wb_dat_i,
   output logic      [31:0]                       wb_dat_o,
   output logic                                   wb_ack_o,
   // timer side
   input  wire logic                              counter_running,
   input  wire logic [PIN_COUNT-1:0]              pwm_level,
   input  wire logic                              cutoff_request,
   // general port side
   input  wire pwm_cutoff_pkg::pin_drive_type [PIN_COUNT-1:0] port_drive,
   // pins
   output pwm_cutoff_pkg::pin_drive_type [PIN_COUNT-1:0]      pin_drive
);

   // ==========================================================
   // parameter check
   if (PIN_COUNT != 2 * `PINS_PER_CHANNEL)
   begin : g_bad_pins
      $error("pin count must be eight");
   end
   if (ADDR_WIDTH < 5)
   begin : g_bad_addr
      $error("address width too small");
   end

   // ==========================================================
   // state
   logic [7:0]              ch0_pin_cutoff_select;
   logic [7:0]              channel1_pin_cutoff_select;
   logic [7:0]              pin_output_master_disable;
   logic                    force_cutoff;
   logic [31:0]             next_dat;
   logic                    next_ack;
   logic [7:0]              next_ch0;
   logic [7:0]              next_ch1;
   logic [7:0]              next_disable;
   logic                    next_force;
   logic                    req_meta;
   logic                    req_sync;
   logic                    cutoff_active;
   logic [PIN_COUNT-1:0]    drive_oe;
   logic [PIN_COUNT-1:0]    drive_level;
   logic [7:0]              adr;
   logic                    access;
   logic                    write_commit;

   // ==========================================================
   // field extraction
   function automatic pwm_cutoff_pkg::cutoff_mode_type field_of(input logic [7:0] value, input int pin);
      logic [1:0] bits;
      bits = value[`CUTOFF_PIN_D_LSB +: 2];
      case (pin % `PINS_PER_CHANNEL)
         0: bits = value[`CUTOFF_PIN_A_LSB +: 2];
         1: bits = value[`CUTOFF_PIN_B_LSB +: 2];
         2: bits = value[`CUTOFF_PIN_C_LSB +: 2];
         default: bits = value[`CUTOFF_PIN_D_LSB +: 2];
      endcase
      return pwm_cutoff_pkg::cutoff_mode_type'(bits);
   endfunction

   // ==========================================================
   // cutoff request synchroniser
   always_ff @(posedge sys_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         req_meta <= 1'b0;
         req_sync <= 1'b0;
      end
      else
      begin
         req_meta <= cutoff_request;
         req_sync <= req_meta;
      end
   end

   assign cutoff_active = req_sync | force_cutoff;

   // ==========================================================
   // register bus
   assign adr    = 8'(wb_adr_i);
   assign access = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   // writes land on the edge where the master sees ack
   assign write_commit = wb_cyc_i & wb_stb_i & wb_ack_o & wb_we_i & wb_sel_i[0];

   always_comb
   begin
      next_ack     = access;
      next_dat     = wb_dat_o;
      next_ch0     = ch0_pin_cutoff_select;
      next_ch1     = channel1_pin_cutoff_select;
      next_disable = pin_output_master_disable;
      next_force   = force_cutoff;
      if (access && !wb_we_i)
      begin
         next_dat = 32'h0;
         if (adr == `OFFS_CH0_CUTOFF)
         begin
            next_dat[7:0] = ch0_pin_cutoff_select;
         end
         else if (adr == `OFFS_CH1_CUTOFF)
         begin
            next_dat[7:0] = channel1_pin_cutoff_select;
         end
         else if (adr == `OFFS_MASTER_DISABLE)
         begin
            next_dat[7:0] = pin_output_master_disable;
         end
         else if (adr == `OFFS_CONTROL)
         begin
            next_dat[`CTRL_FORCE_BIT] = force_cutoff;
         end
         else if (adr == `OFFS_STATUS)
         begin
            next_dat[`STAT_ACTIVE_BIT]             = cutoff_active;
            next_dat[`STAT_RUNNING_BIT]            = counter_running;
            next_dat[`STAT_OE_LSB +: PIN_COUNT]    = drive_oe;
            next_dat[`STAT_LEVEL_LSB +: PIN_COUNT] = drive_level;
         end
      end
      else if (write_commit)
      begin
         if (adr == `OFFS_CH0_CUTOFF && !counter_running)
         begin
            next_ch0 = wb_dat_i[7:0];
         end
         else if (adr == `OFFS_CH1_CUTOFF && !counter_running)
         begin
            next_ch1 = wb_dat_i[7:0];
         end
         else if (adr == `OFFS_MASTER_DISABLE)
         begin
            next_disable = wb_dat_i[7:0];
         end
         else if (adr == `OFFS_CONTROL)
         begin
            next_force = wb_dat_i[`CTRL_FORCE_BIT];
         end
      end
   end

   always_ff @(posedge sys_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         wb_ack_o                   <= 1'b0;
         wb_dat_o                   <= 32'h0;
         ch0_pin_cutoff_select      <= `RST_CUTOFF;
         channel1_pin_cutoff_select <= `RST_CUTOFF;
         pin_output_master_disable  <= `RST_MASTER_DISABLE;
         force_cutoff               <= `RST_CONTROL;
      end
      else
      begin
         wb_ack_o                   <= next_ack;
         wb_dat_o                   <= next_dat;
         ch0_pin_cutoff_select      <= next_ch0;
         channel1_pin_cutoff_select <= next_ch1;
         pin_output_master_disable  <= next_disable;
         force_cutoff               <= next_force;
      end
   end

   // ==========================================================
   // pin stages
   for (genvar p = 0; p < PIN_COUNT; p++)
   begin : g_pin
      pwm_pin_stage u_stage
      (
         .sys_clk       (sys_clk),
         .sys_rst       (sys_rst),
         .pin_disable   (pin_output_master_disable[p]),
         .cutoff_active (cutoff_active),
         .cutoff_mode   ((p < `PINS_PER_CHANNEL) ? field_of(ch0_pin_cutoff_select, p)
                                                 : field_of(channel1_pin_cutoff_select, p)),
         .pwm_level     (pwm_level[p]),
         .port_drive    (port_drive[p]),
         .pin_drive     (pin_drive[p])
      );
      assign drive_oe[p]    = pin_drive[p].enable;
      assign drive_level[p] = pin_drive[p].level;
   end

endmodule

// ==== pwm_cutoff_map.svh ====
`ifndef PWM_CUTOFF_MAP_SVH
`define PWM_CUTOFF_MAP_SVH

// ==========================================================
// register byte offsets
`define OFFS_CH0_CUTOFF     8'h00
`define OFFS_CH1_CUTOFF     8'h04
`define OFFS_MASTER_DISABLE 8'h08
`define OFFS_CONTROL        8'h0c
`define OFFS_STATUS         8'h10

// ==========================================================
// reset values
`define RST_CUTOFF          8'h00
`define RST_MASTER_DISABLE  8'hff
`define RST_CONTROL         1'h0

// ==========================================================
// field positions
`define CUTOFF_PIN_A_LSB    6
`define CUTOFF_PIN_B_LSB    4
`define CUTOFF_PIN_C_LSB    2
`define CUTOFF_PIN_D_LSB    0
`define CTRL_FORCE_BIT      0
`define STAT_ACTIVE_BIT     0
`define STAT_RUNNING_BIT    1
`define STAT_OE_LSB         8
`define STAT_LEVEL_LSB      16
`define PINS_PER_CHANNEL    4

`endif

// ==== pwm_cutoff_pkg.sv ====
package pwm_cutoff_pkg;

   // ==========================================================
   // cutoff field encodings
   typedef enum logic [1:0]
   {
      cutoff_off   = 2'h0,
      cutoff_hiz   = 2'h1,
      cutoff_low   = 2'h2,
      cutoff_high  = 2'h3
   } cutoff_mode_type;

   // ==========================================================
   // drive of one pin
   typedef struct packed
   {
      logic level;
      logic enable;
   } pin_drive_type;

endpackage

// ==== pwm_pin_stage.sv ====
`timescale 1ns/1ns
module pwm_pin_stage
(
   // clock and reset
   input  wire logic                          sys_clk,
   input  wire logic                          sys_rst,
   // selection
   input  wire logic                          pin_disable,
   input  wire logic                          cutoff_active,
   input  wire pwm_cutoff_pkg::cutoff_mode_type cutoff_mode,
   // sources
   input  wire logic                          pwm_level,
   input  wire pwm_cutoff_pkg::pin_drive_type  port_drive,
   // pin
   output pwm_cutoff_pkg::pin_drive_type       pin_drive
);

   pwm_cutoff_pkg::pin_drive_type next_pin_drive;

   // ==========================================================
   // output selection
   always_comb
   begin
      next_pin_drive.level  = pwm_level;
      next_pin_drive.enable = 1'b1;
      if (pin_disable)
      begin
         next_pin_drive = port_drive;
      end
      else if (cutoff_active)
      begin
         case (cutoff_mode)
            pwm_cutoff_pkg::cutoff_hiz:
            begin
               next_pin_drive.level  = 1'b0;
               next_pin_drive.enable = 1'b0;
            end
            pwm_cutoff_pkg::cutoff_low:
            begin
               next_pin_drive.level  = 1'b0;
               next_pin_drive.enable = 1'b1;
            end
            pwm_cutoff_pkg::cutoff_high:
            begin
               next_pin_drive.level  = 1'b1;
               next_pin_drive.enable = 1'b1;
            end
            default:
            begin
               next_pin_drive.level  = pwm_level;
               next_pin_drive.enable = 1'b1;
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         pin_drive <= '0;
      end
      else
      begin
         pin_drive <= next_pin_drive;
      end
   end

endmodule

// ==== pwm_cutoff_ctrl_properties.sv ====
`timescale 1ns/1ns
module pwm_cutoff_ctrl_checker
#(
   parameter int ADDR_WIDTH = 8,
   parameter int PIN_COUNT  = 8
)
(
   // clock and bus
   input wire logic                  sys_clk,
   input wire logic                  sys_rst,
   input wire logic                  wb_cyc_i,
   input wire logic                  wb_stb_i,
   input wire logic                  wb_we_i,
   input wire logic [ADDR_WIDTH-1:0] wb_adr_i,
   input wire logic [3:0]            wb_sel_i,
   input wire logic [31:0]           wb_dat_i,
   input wire logic [31:0]           wb_dat_o,
   input wire logic                  wb_ack_o,
   // timer, port and pins
   input wire logic                  counter_running,
   input wire logic [PIN_COUNT-1:0]  pwm_level,
   input wire logic                  cutoff_request,
   input wire pwm_cutoff_pkg::pin_drive_type [PIN_COUNT-1:0] port_drive,
   input wire pwm_cutoff_pkg::pin_drive_type [PIN_COUNT-1:0] pin_drive
);
   // ==========
   // shadow registers and expected pins
   logic [7:0]             dis, cf0, cf1, rdv;
   logic                   frc;
   logic [1:0]             syn, f;
   logic [2*PIN_COUNT-1:0] exp_pin, dmask;
   wire                    req = wb_cyc_i && wb_stb_i && !wb_ack_o;
   wire                    wr  = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_sel_i[0];
   wire                    act = syn[1] || frc;

   always_ff @(posedge sys_clk or posedge sys_rst)
      if (sys_rst)
      begin
         dis <= 8'hff;
         cf0 <= 8'h00;
         cf1 <= 8'h00;
         frc <= 1'b0;
         syn <= 2'h0;
      end
      else
      begin
         syn <= {syn[0], cutoff_request};
         if (wr && wb_adr_i == 8'h08) dis <= wb_dat_i[7:0];
         if (wr && wb_adr_i == 8'h0c) frc <= wb_dat_i[0];
         if (wr && wb_adr_i == 8'h00 && !counter_running) cf0 <= wb_dat_i[7:0];
         if (wr && wb_adr_i == 8'h04 && !counter_running) cf1 <= wb_dat_i[7:0];
      end

   always_comb
   begin
      rdv = (wb_adr_i == 8'h00) ? cf0 : (wb_adr_i == 8'h04) ? cf1 :
            (wb_adr_i == 8'h08) ? dis : (wb_adr_i == 8'h0c) ? {7'h0, frc} : 8'h00;
      f = 2'h0;
      for (int i = 0; i < PIN_COUNT; i++)
      begin
         f = (i < 4) ? cf0[7-2*i -: 2] : cf1[15-2*i -: 2];
         dmask[2*i +: 2] = {2{dis[i]}};
         if (dis[i]) exp_pin[2*i +: 2] = port_drive[i];
         else if (act && f != 2'h0) exp_pin[2*i +: 2] = {f[1] & f[0], f[1]};
         else exp_pin[2*i +: 2] = {pwm_level[i], 1'b1};
      end
   end

   // ==========
   // assertions
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (sys_rst);

   a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held too long");
   a_ack_answer: assert property (req |=> wb_ack_o) else $error("request not answered");
   a_ack_cause: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i)) else $error("ack without request");
   a_data_hold: assert property (!wb_ack_o |-> $stable(wb_dat_o)) else $error("read data moved");
   a_read_back: assert property (req && !wb_we_i && wb_adr_i != 8'h10 |=> wb_dat_o == {24'h0, $past(rdv)})
      else $error("read data wrong");
   a_read_status: assert property (req && !wb_we_i && wb_adr_i == 8'h10 |=> wb_dat_o[1:0] == $past({counter_running, act}))
      else $error("status wrong");
   a_pin_select: assert property (!$past(sys_rst) |-> {pin_drive} == $past(exp_pin))
      else $error("pin drive wrong");
   a_port_handover: assert property (!$past(sys_rst) |-> (({pin_drive} ^ $past({port_drive})) & $past(dmask)) == 16'h0)
      else $error("disabled pin not from port");
endmodule

// ==== pwm_load_model.sv ====
`timescale 1ns/1ns
module pwm_load_model
(
   // pins and pads
   input  wire pwm_cutoff_pkg::pin_drive_type [7:0] pin_drive,
   output logic [7:0]                               pad
);
   // ==========
   // load with pull-down: an undriven pin reads low
   always_comb
      for (int i = 0; i < 8; i++)
         pad[i] = pin_drive[i].enable ? pin_drive[i].level : 1'b0;
endmodule

// ==== pwm_cutoff_ctrl_tb.sv ====
`timescale 1ns/1ns
module pwm_cutoff_ctrl_tb;
   logic        sys_clk, sys_rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, counter_running, cutoff_request;
   logic [7:0]  wb_adr_i, pwm_level, pad;
   logic [3:0]  wb_sel_i;
   logic [31:0] wb_dat_i, wb_dat_o, rdat;
   pwm_cutoff_pkg::pin_drive_type [7:0] port_drive, pin_drive;
   int          miscompares, cmp_count;
   logic [1:0]  combination_mode;

   pwm_cutoff_ctrl dut (.sys_clk, .sys_rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
      .wb_dat_o, .wb_ack_o, .counter_running, .pwm_level, .cutoff_request, .port_drive, .pin_drive);
   pwm_load_model load (.pin_drive, .pad);

   // ==========
   // clock, compare, bus
   initial
   begin
      sys_clk = 1'b0;
      forever #20 sys_clk = ~sys_clk;
   end

   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         miscompares++;
         $display("BAD %0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic end_sim;
      $display("compares %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
      int n;
      @(posedge sys_clk);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= w;
      wb_adr_i <= a;
      wb_dat_i <= d;
      wb_sel_i <= s;
      for (n = 0; n < 20 && wb_ack_o !== 1'b1; n++)
         @(posedge sys_clk);
      if (wb_ack_o !== 1'b1)
      begin
         miscompares++;
         end_sim();
      end
      rdat = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0, 4'hf);
      cmp(rdat, e);
   endtask

   task automatic pins_chk(input logic [15:0] e);
      repeat (4) @(posedge sys_clk);
      cmp({16'h0, pin_drive}, {16'h0, e});
   endtask

   // ==========
   // scenarios
   task automatic s_regs;
      rd(8'h00, 32'h0);
      rd(8'h04, 32'h0);
      bus(1'b1, 8'h14, 32'h5a, 4'h1);
      rd(8'h14, 32'h0);
      bus(1'b1, 8'h08, 32'h0f, 4'h0);
      rd(8'h08, 32'hff);
   endtask

   task automatic s_handover;
      bus(1'b1, 8'h08, {28'h0, 3'h7, combination_mode == 2'h1}, 4'h1);
      rd(8'h08, 32'h0f);
      pins_chk(16'hdd36);
   endtask

   task automatic s_cutoff;
      bus(1'b1, 8'h08, 32'h03, 4'h1);
      bus(1'b1, 8'h00, 32'h0e, 4'h1);
      bus(1'b1, 8'h04, 32'he4, 4'h1);
      rd(8'h04, 32'he4);
      pins_chk(16'hdd76);
      bus(1'b1, 8'h0c, 32'h1, 4'h1);
      pins_chk(16'hc776);
      cmp({24'h0, pad}, 32'h94);
      bus(1'b1, 8'h0c, 32'h0, 4'h1);
      cutoff_request <= 1'b1;
      pins_chk(16'hc776);
      rd(8'h10, 32'h0095be01);
      cutoff_request <= 1'b0;
      pins_chk(16'hdd76);
   endtask

   task automatic s_locked;
      counter_running <= 1'b1;
      bus(1'b1, 8'h04, 32'h1b, 4'h1);
      rd(8'h04, 32'he4);
      rd(8'h10, 32'h00a5fe02);
      counter_running <= 1'b0;
   endtask

   initial
   begin
      miscompares = 0;
      cmp_count = 0;
      {sys_rst, wb_cyc_i, wb_stb_i, wb_we_i, counter_running, cutoff_request} = 6'h20;
      {wb_adr_i, wb_sel_i, wb_dat_i} = 44'h0;
      pwm_level = 8'ha5;
      combination_mode = 2'h1;
      port_drive = 16'h9c36;
      repeat (16) @(posedge sys_clk);
      sys_rst <= 1'b0;
      s_regs();
      s_handover();
      s_cutoff();
      s_locked();
      sys_rst <= 1'b1;
      @(posedge sys_clk);
      sys_rst <= 1'b0;
      rd(8'h08, 32'hff);
      pins_chk(16'h9c36);
      end_sim();
   end
endmodule

bind pwm_cutoff_ctrl pwm_cutoff_ctrl_checker #(.ADDR_WIDTH(ADDR_WIDTH), .PIN_COUNT(PIN_COUNT)) chk (.sys_clk, .sys_rst,
   .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .counter_running,
   .pwm_level, .cutoff_request, .port_drive, .pin_drive);
